// ---- hdl/nvmseq_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 16-bit special register bus, 24-bit program address
// Notes: definitions only, included by bare name
`ifndef NVMSEQ_MAP_SVH
`define NVMSEQ_MAP_SVH

// ==============================================================
// Register offsets
`define NVM_ADDR_CONTROL 16'h0920
`define NVM_ADDR_LOW 16'h0762
`define NVM_ADDR_UP 16'h0764
`define NVM_ADDR_KEY 16'h0766

// ==============================================================
// Control register fields
`define NVM_BIT_START 15
`define NVM_BIT_PERMIT 14
`define NVM_BIT_ERROR 13
`define NVM_BIT_TIMING 8
`define NVM_OPSEL_MSB 6
`define NVM_RESET_WORD 16'h0000
`define NVM_RESET_UP 8'h00

// ==============================================================
// Unlock keys and operation codes
`define NVM_KEY_FIRST 8'h55
`define NVM_KEY_SECOND 8'hAA
`define NVM_OP_EE_BLK_ERASE 7'h45
`define NVM_OP_EE_WORD_ERASE 7'h44
`define NVM_OP_EE_WORD_PROG 7'h04
`define NVM_OP_EE_BLK_PROG 7'h0A

// ==============================================================
// Data EEPROM window and contents
`define NVM_EE_BASE 24'h7FF000
`define NVM_EE_LAST 24'h7FFFFE
`define NVM_ERASED_WORD 16'hFFFF
`define NVM_BUSY_READ_DATA 16'h0000

// ==============================================================
// Cycle timing
`define NVM_CYCLE_TIME_US 2000
`define NVM_CLK_MHZ 100
`define NVM_CYCLE_CYCLES (`NVM_CYCLE_TIME_US * `NVM_CLK_MHZ)

`endif

// ---- hdl/nvmseq_pkg.sv ----
// Purpose: shared types of the sequencer
// Assumes: nothing beyond the map header
// Notes: imported by no file; always referenced with scope
package nvmseq_pkg;

	// ==============================================================
	// Unlock sequence states
	typedef enum logic [1:0] {
		NVMSEQ_KEY_IDLE,
		NVMSEQ_KEY_FIRST,
		NVMSEQ_KEY_OPEN
	} nvmseq_key_e;

	// ==============================================================
	// Kind of operation latched at start
	typedef enum logic [2:0] {
		NVMSEQ_OP_FLASH,
		NVMSEQ_OP_EE_BLK_ERASE,
		NVMSEQ_OP_EE_WORD_ERASE,
		NVMSEQ_OP_EE_WORD_PROG,
		NVMSEQ_OP_EE_BLK_PROG
	} nvmseq_op_e;

endpackage

// ---- hdl/nvmseq_key_unlock.sv ----
// Purpose: two-key unlock tracker in front of the start bit
// Assumes: one special register write per cycle at most
// Notes: any other register write closes the lock again
`timescale 1ns/1ps
`include "nvmseq_map.svh"

module nvmseq_key_unlock
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Register write snoop
	input wire logic sfr_wr_in,
	input wire logic key_wr_in,
	input wire logic [7:0] key_data_in,
	input wire logic cancel_in,
	// Lock state
	output logic unlocked_out
);

	nvmseq_pkg::nvmseq_key_e state_reg;
	nvmseq_pkg::nvmseq_key_e state_next;

	// Next state of the key sequence
	always_comb
	begin
		state_next = state_reg;
		if (cancel_in)
			state_next = nvmseq_pkg::NVMSEQ_KEY_IDLE;
		else if (sfr_wr_in)
		begin
			case (state_reg)
				nvmseq_pkg::NVMSEQ_KEY_FIRST:
					if (key_wr_in && key_data_in == `NVM_KEY_SECOND)
						state_next = nvmseq_pkg::NVMSEQ_KEY_OPEN;
					else if (key_wr_in && key_data_in == `NVM_KEY_FIRST)
						state_next = nvmseq_pkg::NVMSEQ_KEY_FIRST;
					else
						state_next = nvmseq_pkg::NVMSEQ_KEY_IDLE;
				nvmseq_pkg::NVMSEQ_KEY_OPEN:
					state_next = nvmseq_pkg::NVMSEQ_KEY_IDLE; // Start write uses it up
				default:
					if (key_wr_in && key_data_in == `NVM_KEY_FIRST)
						state_next = nvmseq_pkg::NVMSEQ_KEY_FIRST;
					else
						state_next = nvmseq_pkg::NVMSEQ_KEY_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			state_reg <= nvmseq_pkg::NVMSEQ_KEY_IDLE;
		else
			state_reg <= state_next;
	end

	assign unlocked_out = (state_reg == nvmseq_pkg::NVMSEQ_KEY_OPEN);

	chk_key_single_use: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		unlocked_out && sfr_wr_in |=> !unlocked_out)
		else $error("lock stayed open after a write");

	chk_key_needs_pair: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(unlocked_out) |-> $past(key_wr_in) && $past(key_data_in) == `NVM_KEY_SECOND)
		else $error("lock opened without second key");

endmodule // nvmseq_key_unlock

// ---- hdl/nvmseq_cycle_timer.sv ----
// Purpose: times one erase or program cycle
// Assumes: start is ignored while a cycle runs
// Notes: abort ends the cycle at once without a done pulse
`timescale 1ns/1ps

module nvmseq_cycle_timer #(
	parameter int unsigned CYCLE_COUNT = 200000
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic start_in,
	input wire logic abort_in,
	// Status
	output logic busy_out,
	output logic done_out
);

	localparam int unsigned CNT_W = $clog2(CYCLE_COUNT + 1);

	logic busy_reg;
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			busy_reg <= 1'b0;
			cnt_reg <= '0;
		end
		else if (abort_in)
			busy_reg <= 1'b0;
		else if (!busy_reg && start_in)
		begin
			busy_reg <= 1'b1;
			cnt_reg <= CNT_W'(CYCLE_COUNT - 1);
		end
		else if (busy_reg && cnt_reg == '0)
			busy_reg <= 1'b0;
		else if (busy_reg)
			cnt_reg <= cnt_reg - 1'b1;
	end

	assign busy_out = busy_reg;
	assign done_out = busy_reg && cnt_reg == '0 && !abort_in;

	chk_timer_load: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_in && !busy_reg && !abort_in |=> busy_reg && cnt_reg == CNT_W'(CYCLE_COUNT - 1))
		else $error("timer not loaded with cycle count");

endmodule // nvmseq_cycle_timer

// ---- hdl/nvmseq_top.sv ----
// Purpose: erase and program sequencer for the data EEPROM
// Assumes: CPU special register and table ports on the same clock
// Notes: program flash cycles are timed and stall the CPU only
`timescale 1ns/1ps
`include "nvmseq_map.svh"

// How it works
// - no start without both unlock keys
// - EEPROM sits in program space, same registers
// - single word and sixteen word operations
// - lower plus upper register form address
// - 2K words from 0x7FF000 to 0x7FFFFE
// - write cycle lasts about two milliseconds
// - EEPROM cycles never stall the CPU
// - reads during a cycle return junk
// - start bit set by software, cleared by hardware
// - writes allowed only with permit bit, reset clear
// - warm reset during cycle sets error flag
// - abort keeps lower address register contents
// - done sets interrupt flag, software clears it
// - table read returns word at page:pointer
// - block erase sequence erases addressed block
// - unused bits read zero, lower address unreset
// - start at bit 15, flash cycles stall CPU
// - start and permit together are ignored
module nvmseq_top #(
	parameter int unsigned CYCLE_COUNT = `NVM_CYCLE_CYCLES,
	parameter int unsigned EE_WORDS = 4096,
	parameter int unsigned BLOCK_WORDS = 16
)
(
	// Clock and power-on reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Warm reset events, one-cycle pulses
	input wire logic master_clear_rst_in,
	input wire logic watchdog_rst_in,
	// Special register port
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [15:0] sfr_addr_in,
	input wire logic [15:0] sfr_wdata_in,
	output logic [15:0] sfr_rdata_out,
	// Table instruction port
	input wire logic tbl_rd_in,
	input wire logic tbl_wr_in,
	input wire logic [7:0] tbl_page_in,
	input wire logic [15:0] tbl_offset_in,
	input wire logic [15:0] tbl_wdata_in,
	output logic [15:0] tbl_rdata_out,
	output logic tbl_rvalid_out,
	// Completion flag and CPU status
	input wire logic done_irq_clr_in,
	output logic nvm_done_irq_flag_out,
	output logic cpu_stall_out,
	output logic busy_out
);

	localparam int unsigned IDX_W = $clog2(EE_WORDS);
	localparam int unsigned LANE_W = $clog2(BLOCK_WORDS);

	// ==============================================================
	// Address decode helpers

	function automatic logic ee_hit(input logic [23:0] a);
		return (a >= `NVM_EE_BASE) && (a <= `NVM_EE_LAST);
	endfunction

	// Word index inside the EEPROM, byte bit dropped
	function automatic logic [IDX_W-1:0] ee_index(input logic [23:0] a);
		return a[IDX_W:1];
	endfunction

	// ==============================================================
	// Declarations
	logic warm_rst;
	logic ctl_wr;
	logic key_wr;
	logic start_req;
	logic start_ok;
	logic unlocked;
	logic busy;
	logic done;
	logic done_ee;
	logic [23:0] tbl_addr;
	logic [15:0] ctl_view;
	logic ctl_start_reg;
	logic ctl_permit_reg;
	logic ctl_error_reg;
	logic ctl_timing_reg;
	logic [6:0] ctl_opsel_reg;
	logic [15:0] addr_low_reg;
	logic [7:0] addr_up_reg;
	nvmseq_pkg::nvmseq_op_e op_kind_reg;
	nvmseq_pkg::nvmseq_op_e op_kind_next;
	logic [IDX_W-1:0] op_idx_reg;
	logic [15:0] wlatch_reg [BLOCK_WORDS];
	logic [15:0] mem_reg [EE_WORDS];
	logic [BLOCK_WORDS-1:0] lane_we;
	logic [15:0] lane_val [BLOCK_WORDS];
	logic irq_flag_reg;
	logic [15:0] sfr_rdata_reg;
	logic [15:0] tbl_rdata_reg;
	logic tbl_rvalid_reg;

	// ==============================================================
	// Request decode
	assign warm_rst = master_clear_rst_in | watchdog_rst_in;
	assign ctl_wr = sfr_wr_in && sfr_addr_in == `NVM_ADDR_CONTROL;
	assign key_wr = sfr_wr_in && sfr_addr_in == `NVM_ADDR_KEY;
	assign tbl_addr = {tbl_page_in, tbl_offset_in};
	assign start_req = ctl_wr && sfr_wdata_in[`NVM_BIT_START];

	assign start_ok = start_req && unlocked && ctl_permit_reg && !busy && !warm_rst;

	// ==============================================================
	// Unlock tracker and cycle timer
	nvmseq_key_unlock u_key
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.sfr_wr_in(sfr_wr_in),
		.key_wr_in(key_wr),
		.key_data_in(sfr_wdata_in[7:0]),
		.cancel_in(warm_rst),
		.unlocked_out(unlocked)
	);

	nvmseq_cycle_timer #(
		.CYCLE_COUNT(CYCLE_COUNT)
	) u_timer
	(
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.start_in(start_ok),
		.abort_in(warm_rst),
		.busy_out(busy),
		.done_out(done)
	);

	// ==============================================================
	// Control register

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ctl_start_reg <= 1'b0;
		else if (warm_rst || done)
			ctl_start_reg <= 1'b0;
		else if (start_ok)
			ctl_start_reg <= 1'b1;
	end

	// permit clear from power-up; clearing it mid-cycle is harmless
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ctl_permit_reg <= 1'b0;
		else if (warm_rst)
			ctl_permit_reg <= 1'b0;
		else if (ctl_wr)
			ctl_permit_reg <= sfr_wdata_in[`NVM_BIT_PERMIT];
	end

	// abort by warm reset; set wins over software clear
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			ctl_error_reg <= 1'b0;
		else if (warm_rst && busy)
			ctl_error_reg <= 1'b1;
		else if (ctl_wr && !sfr_wdata_in[`NVM_BIT_ERROR])
			ctl_error_reg <= 1'b0;
	end

	// Mode fields frozen during a cycle so status stays truthful
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			ctl_timing_reg <= 1'b0;
			ctl_opsel_reg <= '0;
		end
		else if (warm_rst)
		begin
			ctl_timing_reg <= 1'b0;
			ctl_opsel_reg <= '0;
		end
		else if (ctl_wr && !busy)
		begin
			ctl_timing_reg <= sfr_wdata_in[`NVM_BIT_TIMING];
			ctl_opsel_reg <= sfr_wdata_in[`NVM_OPSEL_MSB:0];
		end
	end

	// ==============================================================
	// Address registers

	always_ff @(posedge clk_in)
	begin
		if (sfr_wr_in && sfr_addr_in == `NVM_ADDR_LOW)
			addr_low_reg <= sfr_wdata_in;
		else if (tbl_rd_in || tbl_wr_in)
			addr_low_reg <= tbl_offset_in; // Last table access captured
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			addr_up_reg <= `NVM_RESET_UP;
		else if (warm_rst)
			addr_up_reg <= `NVM_RESET_UP;
		else if (sfr_wr_in && sfr_addr_in == `NVM_ADDR_UP)
			addr_up_reg <= sfr_wdata_in[7:0];
		else if (tbl_rd_in || tbl_wr_in)
			addr_up_reg <= tbl_page_in;
	end

	// ==============================================================
	// Operation latched at start

	// same registers for flash and EEPROM
	always_comb
	begin
		op_kind_next = nvmseq_pkg::NVMSEQ_OP_FLASH;
		if (ee_hit({addr_up_reg, addr_low_reg}))
		begin
			case (ctl_opsel_reg)
				`NVM_OP_EE_BLK_ERASE: op_kind_next = nvmseq_pkg::NVMSEQ_OP_EE_BLK_ERASE;
				`NVM_OP_EE_WORD_ERASE: op_kind_next = nvmseq_pkg::NVMSEQ_OP_EE_WORD_ERASE;
				`NVM_OP_EE_WORD_PROG: op_kind_next = nvmseq_pkg::NVMSEQ_OP_EE_WORD_PROG;
				`NVM_OP_EE_BLK_PROG: op_kind_next = nvmseq_pkg::NVMSEQ_OP_EE_BLK_PROG;
				default: op_kind_next = nvmseq_pkg::NVMSEQ_OP_FLASH;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			op_kind_reg <= nvmseq_pkg::NVMSEQ_OP_FLASH;
			op_idx_reg <= '0;
		end
		else if (start_ok)
		begin
			op_kind_reg <= op_kind_next;
			op_idx_reg <= ee_index({addr_up_reg, addr_low_reg});
		end
	end

	// ==============================================================
	// Write latches, loaded by table writes into the window
	always_ff @(posedge clk_in)
	begin
		if (tbl_wr_in && ee_hit(tbl_addr))
			wlatch_reg[tbl_addr[LANE_W:1]] <= tbl_wdata_in;
	end

	// ==============================================================
	// Commit of a finished EEPROM cycle, one lane per block word
	assign done_ee = done && op_kind_reg != nvmseq_pkg::NVMSEQ_OP_FLASH;

	for (genvar g = 0; g < BLOCK_WORDS; g++)
	begin : g_lane
		logic own_word;
		assign own_word = op_idx_reg[LANE_W-1:0] == LANE_W'(g);
		always_comb
		begin
			lane_we[g] = 1'b0;
			lane_val[g] = `NVM_ERASED_WORD;
			case (op_kind_reg)
				nvmseq_pkg::NVMSEQ_OP_EE_BLK_ERASE: lane_we[g] = done_ee;
				nvmseq_pkg::NVMSEQ_OP_EE_WORD_ERASE: lane_we[g] = done_ee && own_word;
				nvmseq_pkg::NVMSEQ_OP_EE_WORD_PROG:
				begin
					lane_we[g] = done_ee && own_word;
					lane_val[g] = wlatch_reg[g];
				end
				nvmseq_pkg::NVMSEQ_OP_EE_BLK_PROG:
				begin
					lane_we[g] = done_ee;
					lane_val[g] = wlatch_reg[g];
				end
				default: lane_we[g] = 1'b0;
			endcase
		end
	end

	// Array contents; aborted cycles leave the old word in place
	always_ff @(posedge clk_in)
	begin
		for (int i = 0; i < BLOCK_WORDS; i++)
			if (lane_we[i])
				mem_reg[{op_idx_reg[IDX_W-1:LANE_W], LANE_W'(i)}] <= lane_val[i];
	end

	// ==============================================================
	// Completion flag

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			irq_flag_reg <= 1'b0;
		else if (done)
			irq_flag_reg <= 1'b1;
		else if (done_irq_clr_in)
			irq_flag_reg <= 1'b0;
	end

	// ==============================================================
	// Read paths

	always_comb
	begin
		ctl_view = `NVM_RESET_WORD;
		ctl_view[`NVM_BIT_START] = ctl_start_reg;
		ctl_view[`NVM_BIT_PERMIT] = ctl_permit_reg;
		ctl_view[`NVM_BIT_ERROR] = ctl_error_reg;
		ctl_view[`NVM_BIT_TIMING] = ctl_timing_reg;
		ctl_view[`NVM_OPSEL_MSB:0] = ctl_opsel_reg;
	end

	// Register read data one cycle after the strobe; key reads zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			sfr_rdata_reg <= `NVM_RESET_WORD;
		else if (sfr_rd_in)
		begin
			case (sfr_addr_in)
				`NVM_ADDR_CONTROL: sfr_rdata_reg <= ctl_view;
				`NVM_ADDR_LOW: sfr_rdata_reg <= addr_low_reg;
				`NVM_ADDR_UP: sfr_rdata_reg <= {8'h00, addr_up_reg};
				default: sfr_rdata_reg <= `NVM_RESET_WORD;
			endcase
		end
	end

	// fixed junk while a cycle runs
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			tbl_rdata_reg <= `NVM_RESET_WORD;
			tbl_rvalid_reg <= 1'b0;
		end
		else
		begin
			tbl_rvalid_reg <= tbl_rd_in;
			if (tbl_rd_in)
			begin
				if (busy)
					tbl_rdata_reg <= `NVM_BUSY_READ_DATA;
				else if (ee_hit(tbl_addr))
					tbl_rdata_reg <= mem_reg[ee_index(tbl_addr)];
				else
					tbl_rdata_reg <= `NVM_RESET_WORD;
			end
		end
	end

	// ==============================================================
	// Outputs
	assign sfr_rdata_out = sfr_rdata_reg;
	assign tbl_rdata_out = tbl_rdata_reg;
	assign tbl_rvalid_out = tbl_rvalid_reg;
	assign nvm_done_irq_flag_out = irq_flag_reg;
	assign busy_out = busy;
	assign cpu_stall_out = busy && op_kind_reg == nvmseq_pkg::NVMSEQ_OP_FLASH;

	// ==============================================================
	// Checks
	chk_start_needs_key: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		$rose(ctl_start_reg) |-> $past(unlocked) && $past(ctl_permit_reg))
		else $error("cycle started without unlock");

	chk_start_with_permit: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_req && !ctl_permit_reg && !busy |=> !ctl_start_reg)
		else $error("start and permit in one write began a cycle");

	chk_start_holds: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		ctl_start_reg && !done && !warm_rst |=> ctl_start_reg)
		else $error("start bit dropped early");

	chk_start_ends: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		done |=> !ctl_start_reg && !busy && irq_flag_reg)
		else $error("start bit not cleared at completion");

	chk_irq_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		irq_flag_reg && !done_irq_clr_in |=> irq_flag_reg)
		else $error("done flag lost without clear");

	chk_abort_error: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		warm_rst && busy |=> ctl_error_reg && !busy && !ctl_start_reg)
		else $error("abort did not raise error");

	chk_abort_addr: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		warm_rst && !sfr_wr_in && !tbl_rd_in && !tbl_wr_in |=> $stable(addr_low_reg))
		else $error("lower address changed by abort");

	chk_ee_no_stall: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		start_ok && ee_hit({addr_up_reg, addr_low_reg}) && ctl_opsel_reg inside
		{`NVM_OP_EE_BLK_ERASE, `NVM_OP_EE_WORD_ERASE, `NVM_OP_EE_WORD_PROG, `NVM_OP_EE_BLK_PROG}
		|=> busy && !cpu_stall_out)
		else $error("EEPROM cycle stalled the CPU");

	chk_busy_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		tbl_rd_in && busy |=> tbl_rvalid_out && tbl_rdata_out == `NVM_BUSY_READ_DATA)
		else $error("read during cycle not masked");

endmodule // nvmseq_top

// ---- sim/nvmseq_bench.sv ----
// Purpose: self-checking bench for the EEPROM erase and program sequencer
// Assumes: cycle length shortened to 20 clocks; one idle cycle between accesses
// Notes: inputs move 1 ns after the rising edge so sampling never races
`timescale 1ns/1ps
`include "nvmseq_map.svh"

module nvmseq_bench;
	// ==============================================================
	// Signals
	logic clk_in, rst_n_in, master_clear_rst_in, watchdog_rst_in;
	logic sfr_wr_in, sfr_rd_in, tbl_rd_in, tbl_wr_in, done_irq_clr_in;
	logic [15:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out;
	logic [7:0] tbl_page_in;
	logic [15:0] tbl_offset_in, tbl_wdata_in, tbl_rdata_out;
	logic tbl_rvalid_out, nvm_done_irq_flag_out, cpu_stall_out, busy_out;
	int fails, tests_run, cycles;
	logic [15:0] rd_val;

	nvmseq_top #(.CYCLE_COUNT(20)) i_nvmseq_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
		.master_clear_rst_in(master_clear_rst_in), .watchdog_rst_in(watchdog_rst_in),
		.sfr_wr_in(sfr_wr_in),
		.sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
		.sfr_rdata_out(sfr_rdata_out), .tbl_rd_in(tbl_rd_in), .tbl_wr_in(tbl_wr_in),
		.tbl_page_in(tbl_page_in), .tbl_offset_in(tbl_offset_in),
		.tbl_wdata_in(tbl_wdata_in), .tbl_rdata_out(tbl_rdata_out),
		.tbl_rvalid_out(tbl_rvalid_out), .done_irq_clr_in(done_irq_clr_in),
		.nvm_done_irq_flag_out(nvm_done_irq_flag_out), .cpu_stall_out(cpu_stall_out),
		.busy_out(busy_out));

	// ==============================================================
	// Clock, 100 MHz
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk_in)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fails = fails + 1;
			results();
		end
	end

	// ==============================================================
	// Access tasks
	// One idle cycle between accesses keeps each strobe to one edge
	task automatic tick();
		@(posedge clk_in);
		#1;
	endtask

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run = tests_run + 1;
		if (got !== exp)
		begin
			fails = fails + 1;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] addr, input logic [15:0] data);
		tick();
		sfr_wr_in = 1'b1;
		sfr_addr_in = addr;
		sfr_wdata_in = data;
		tick();
		sfr_wr_in = 1'b0;
	endtask

	task automatic rd(input logic [15:0] addr);
		tick();
		sfr_rd_in = 1'b1;
		sfr_addr_in = addr;
		tick();
		sfr_rd_in = 1'b0;
		rd_val = sfr_rdata_out;
	endtask

	task automatic twr(input logic [15:0] offs, input logic [15:0] data);
		tick();
		tbl_wr_in = 1'b1;
		tbl_page_in = 8'h7F;
		tbl_offset_in = offs;
		tbl_wdata_in = data;
		tick();
		tbl_wr_in = 1'b0;
	endtask

	task automatic trd(input logic [15:0] offs);
		tick();
		tbl_rd_in = 1'b1;
		tbl_page_in = 8'h7F;
		tbl_offset_in = offs;
		tick();
		tbl_rd_in = 1'b0;
		check("table valid", 16'h0001, {15'h0000, tbl_rvalid_out});
		rd_val = tbl_rdata_out;
	endtask

	// Permit set by an earlier write, then keys, then start
	// no other access between keys and start
	task automatic go(input logic [15:0] ctrl);
		wr(`NVM_ADDR_CONTROL, ctrl);
		wr(`NVM_ADDR_KEY, 16'h0055);
		wr(`NVM_ADDR_KEY, 16'h00AA);
		wr(`NVM_ADDR_CONTROL, ctrl | 16'h8000);
		tick();
		tick();
	endtask

	// Bounded wait for the cycle to end, then flag set and cleared
	// full cycle time waited out
	// next cycle only after this one ends
	task automatic finish_op();
		int n;
		for (n = 0; n < 200 && busy_out === 1'b1; n++)
			tick();
		check("busy end", 16'h0000, {15'h0000, busy_out});
		rd(`NVM_ADDR_CONTROL);
		check("start cleared", 16'h0000, rd_val & 16'h8000);
		check("done flag", 16'h0001, {15'h0000, nvm_done_irq_flag_out});
		tick();
		check("flag sticky", 16'h0001, {15'h0000, nvm_done_irq_flag_out});
		done_irq_clr_in = 1'b1;
		tick();
		done_irq_clr_in = 1'b0;
		check("flag cleared", 16'h0000, {15'h0000, nvm_done_irq_flag_out});
	endtask

	task automatic results();
		if (fails == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ==============================================================
	// Main sequence
	initial
	begin
		{master_clear_rst_in, watchdog_rst_in, sfr_wr_in, sfr_rd_in, tbl_rd_in, tbl_wr_in} = 6'h00;
		done_irq_clr_in = 1'b0;
		sfr_addr_in = 16'h0000;
		sfr_wdata_in = 16'h0000;
		tbl_page_in = 8'h00;
		tbl_offset_in = 16'h0000;
		tbl_wdata_in = 16'h0000;
		fails = 0;
		tests_run = 0;
		cycles = 0;
		rst_n_in = 1'b0;
		repeat (20) @(posedge clk_in);
		#1;
		rst_n_in = 1'b1;
		// Reset values and unimplemented places
		rd(`NVM_ADDR_CONTROL);
		check("control reset", 16'h0000, rd_val);
		rd(`NVM_ADDR_UP);
		check("upper reset", 16'h0000, rd_val);
		wr(`NVM_ADDR_UP, 16'hFFFF);
		rd(`NVM_ADDR_UP);
		check("upper width", 16'h00FF, rd_val);
		// Every control bit written: start refused, error not settable, gaps zero
		wr(`NVM_ADDR_CONTROL, 16'hFFFF);
		rd(`NVM_ADDR_CONTROL);
		check("control fields", 16'h417F, rd_val);
		rd(`NVM_ADDR_KEY);
		check("key reads zero", 16'h0000, rd_val);
		rd(16'h0770);
		check("unmapped", 16'h0000, rd_val);
		// Table write captures the address into both registers
		twr(16'hF020, 16'h0000);
		rd(`NVM_ADDR_LOW);
		check("addr low", 16'hF020, rd_val);
		rd(`NVM_ADDR_UP);
		check("addr up", 16'h007F, rd_val);
		// Start without keys
		wr(`NVM_ADDR_CONTROL, 16'h4045);
		wr(`NVM_ADDR_CONTROL, 16'hC045);
		tick();
		check("no keys", 16'h0000, {15'h0000, busy_out});
		// Other write between the keys
		wr(`NVM_ADDR_KEY, 16'h0055);
		wr(`NVM_ADDR_LOW, 16'hF020);
		wr(`NVM_ADDR_KEY, 16'h00AA);
		wr(`NVM_ADDR_CONTROL, 16'hC045);
		tick();
		check("keys broken", 16'h0000, {15'h0000, busy_out});
		// Block erase, no stall, start sticky, reads junk while busy
		go(16'h4045);
		check("busy", 16'h0001, {15'h0000, busy_out});
		check("no stall", 16'h0000, {15'h0000, cpu_stall_out});
		wr(`NVM_ADDR_CONTROL, 16'h4045);
		rd(`NVM_ADDR_CONTROL);
		check("start held", 16'hC045, rd_val);
		trd(16'hF020);
		check("busy read", `NVM_BUSY_READ_DATA, rd_val);
		finish_op();
		trd(16'hF03E);
		check("block erased", `NVM_ERASED_WORD, rd_val);
		// Word program then word erase
		twr(16'hF020, 16'h1234);
		go(16'h4004);
		finish_op();
		trd(16'hF020);
		check("word prog", 16'h1234, rd_val);
		twr(16'hF020, 16'h0000);
		go(16'h4044);
		finish_op();
		trd(16'hF020);
		check("word erase", `NVM_ERASED_WORD, rd_val);
		// Sixteen word block program at the top of the window
		for (int i = 0; i < 16; i++)
			twr(16'hFFE0 + 16'(2 * i), 16'hA000 + 16'(i));
		go(16'h400A);
		finish_op();
		trd(16'hFFE0);
		check("block first", 16'hA000, rd_val);
		trd(16'hFFFE);
		check("block last", 16'hA00F, rd_val);
		// Master clear in mid-cycle
		twr(16'hF020, 16'h0000);
		go(16'h4045);
		tick();
		master_clear_rst_in = 1'b1;
		tick();
		master_clear_rst_in = 1'b0;
		tick();
		check("abort busy", 16'h0000, {15'h0000, busy_out});
		check("abort flag", 16'h0000, {15'h0000, nvm_done_irq_flag_out});
		rd(`NVM_ADDR_CONTROL);
		check("abort error", 16'h2000, rd_val);
		rd(`NVM_ADDR_LOW);
		check("addr kept", 16'hF020, rd_val);
		// Start and permit in one write refused
		wr(`NVM_ADDR_KEY, 16'h0055);
		wr(`NVM_ADDR_KEY, 16'h00AA);
		wr(`NVM_ADDR_CONTROL, 16'hC045);
		tick();
		check("same write", 16'h0000, {15'h0000, busy_out});
		// Watchdog in mid-cycle, error cleared first
		wr(`NVM_ADDR_CONTROL, 16'h0000);
		go(16'h4045);
		watchdog_rst_in = 1'b1;
		tick();
		watchdog_rst_in = 1'b0;
		rd(`NVM_ADDR_CONTROL);
		check("watchdog error", 16'h2000, rd_val);
		// Flash address stalls the processor
		wr(`NVM_ADDR_UP, 16'h0000);
		wr(`NVM_ADDR_LOW, 16'h1000);
		go(16'h4041);
		check("flash stall", 16'h0001, {15'h0000, cpu_stall_out});
		finish_op();
		check("stall end", 16'h0000, {15'h0000, cpu_stall_out});
		results();
	end
endmodule // nvmseq_bench
